// *** core/ldcc_peak.v ***
`include "ldcc_regs.vh"
`default_nettype none

module ldcc_peak (
  input wire clock_i,
  input wire srst_i,
  input wire [3:0] coarse_i,
  input wire [4:0] fine_i,
  input wire strength_i,
  output reg [`LDCC_PEAK_W-1:0] peak_o
);

  reg [11:0] coarse_q;
  reg [10:0] fine_q;
  reg [3:0] scale_q;
  reg [3:0] scale2_q;
  reg [22:0] prod_q;

  wire [11:0] coarse_d;
  wire [10:0] fine_d;
  wire [22:0] prod_d;
  wire [`LDCC_PEAK_W-1:0] peak_d;

  // Three stages keep the multipliers off one long path
  assign coarse_d = `LDCC_COARSE_BASE + `LDCC_COARSE_STEP * {8'h00, coarse_i};
  assign fine_d = `LDCC_FINE_BASE + `LDCC_FINE_STEP * {6'h00, fine_i};
  assign prod_d = {11'h000, coarse_q} * {12'h000, fine_q};
  assign peak_d = {3'h0, prod_q} * {22'h000000, scale2_q};

  always @(posedge clock_i) begin
    if (srst_i) begin
      coarse_q <= 12'h000;
      fine_q <= 11'h000;
      scale_q <= 4'h0;
      scale2_q <= 4'h0;
      prod_q <= 23'h000000;
      peak_o <= 26'h0000000;
    end else begin
      coarse_q <= coarse_d;
      fine_q <= fine_d;
      scale_q <= strength_i ? `LDCC_SCALE_FULL : `LDCC_SCALE_LOW;
      scale2_q <= scale_q;
      prod_q <= prod_d;
      peak_o <= peak_d;
    end
  end

endmodule // ldcc_peak

`default_nettype wire

// *** core/ldcc_top.v ***
// Function
// - Driver 1 bit 13: full or 40% strength
// - Driver 2 bit 13: full or 40% strength
// - Driver 1 bits 6:4 set edge rate
// - Driver 2 bits 6:4 set edge rate
// - Driver 1 bits 3:0 coarse target, reset zero
// - Driver 2 bits 3:0 coarse target, reset zero
// - Driver 1 peak: coarse times fine times scale
// - Driver 2 peak uses fine bits 10:6
// - Fine fields five bits, reset to 0xC
`include "ldcc_regs.vh"
`default_nettype none

module ldcc_top (
  input wire clock_i,
  input wire srst_i,
  input wire [`LDCC_ADDR_W-1:0] reg_addr_i,
  input wire [15:0] reg_wdata_i,
  input wire reg_wr_i,
  input wire reg_rd_i,
  output reg [15:0] reg_rdata_o,
  output reg reg_rd_valid_o,
  output reg reg_wr_ack_o,
  output reg reg_addr_err_o,
  output reg drv1_strength_select_o,
  output reg drv1_low_power_o,
  output reg [2:0] drv1_edge_rate_o,
  output reg [3:0] drv1_coarse_target_o,
  output reg [4:0] drv1_fine_multiplier_o,
  output reg drv1_rsvd_ok_o,
  output reg drv1_cfg_update_o,
  output wire [`LDCC_PEAK_W-1:0] drv1_peak_o,
  output reg drv2_strength_select_o,
  output reg drv2_low_power_o,
  output reg [2:0] drv2_edge_rate_o,
  output reg [3:0] drv2_coarse_target_o,
  output reg [4:0] drv2_fine_multiplier_o,
  output reg drv2_rsvd_ok_o,
  output reg drv2_cfg_update_o,
  output wire [`LDCC_PEAK_W-1:0] drv2_peak_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Address decode

  wire hit_drv1;
  wire hit_drv2;
  wire hit_fine;
  wire hit_any;

  // Only the two driver registers and the shared fine register exist
  assign hit_drv1 = (reg_addr_i == `LDCC_OFS_DRV1_CFG);
  assign hit_drv2 = (reg_addr_i == `LDCC_OFS_DRV2_CFG);
  assign hit_fine = (reg_addr_i == `LDCC_OFS_FINE_ADJ);
  assign hit_any = hit_drv1 | hit_drv2 | hit_fine;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage

  reg [15:0] drv1_cfg_q;
  reg [15:0] drv2_cfg_q;
  reg [15:0] fine_adj_q;
  reg [15:0] drv1_cfg_d;
  reg [15:0] drv2_cfg_d;
  reg [15:0] fine_adj_d;

  // Reserved bits are stored as written; keeping them sane is the host's job
  always @* begin
    drv1_cfg_d = drv1_cfg_q;
    drv2_cfg_d = drv2_cfg_q;
    fine_adj_d = fine_adj_q;
    if (reg_wr_i && hit_drv1) begin
      drv1_cfg_d = reg_wdata_i;
    end
    if (reg_wr_i && hit_drv2) begin
      drv2_cfg_d = reg_wdata_i;
    end
    if (reg_wr_i && hit_fine) begin
      fine_adj_d = reg_wdata_i;
    end
  end

  always @(posedge clock_i) begin
    if (srst_i) begin
      drv1_cfg_q <= `LDCC_RST_DRV_CFG;
      drv2_cfg_q <= `LDCC_RST_DRV_CFG;
      fine_adj_q <= `LDCC_RST_FINE_ADJ;
    end else begin
      drv1_cfg_q <= drv1_cfg_d;
      drv2_cfg_q <= drv2_cfg_d;
      fine_adj_q <= fine_adj_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register port answers

  // Unmapped reads give zero and pulse the error flag
  reg [15:0] rdata_d;

  always @* begin
    case (reg_addr_i)
      `LDCC_OFS_DRV1_CFG: begin
        rdata_d = drv1_cfg_q;
      end
      `LDCC_OFS_DRV2_CFG: begin
        rdata_d = drv2_cfg_q;
      end
      `LDCC_OFS_FINE_ADJ: begin
        rdata_d = fine_adj_q;
      end
      default: begin
        rdata_d = 16'h0000;
      end
    endcase
  end

  // Read returns the value held before a same-cycle write
  always @(posedge clock_i) begin
    if (srst_i) begin
      reg_rdata_o <= 16'h0000;
      reg_rd_valid_o <= 1'b0;
      reg_wr_ack_o <= 1'b0;
      reg_addr_err_o <= 1'b0;
    end else begin
      reg_rdata_o <= reg_rd_i ? rdata_d : 16'h0000;
      reg_rd_valid_o <= reg_rd_i;
      reg_wr_ack_o <= reg_wr_i;
      reg_addr_err_o <= (reg_rd_i | reg_wr_i) & ~hit_any;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Driver controls, taken from the next register values so that
  // they line up with the stored registers

  wire drv1_rsvd_ok_d;
  wire drv2_rsvd_ok_d;

  // Goes low for a setting outside the recommended reserved pattern
  assign drv1_rsvd_ok_d =
    (drv1_cfg_d[`LDCC_RSVD_HI_MSB:`LDCC_RSVD_HI_LSB] == 2'h0) &
    drv1_cfg_d[`LDCC_RSVD_ONE_BIT] &
    (drv1_cfg_d[`LDCC_RSVD_MID_MSB:`LDCC_RSVD_MID_LSB] == 5'h00);
  assign drv2_rsvd_ok_d =
    (drv2_cfg_d[`LDCC_RSVD_HI_MSB:`LDCC_RSVD_HI_LSB] == 2'h0) &
    drv2_cfg_d[`LDCC_RSVD_ONE_BIT] &
    (drv2_cfg_d[`LDCC_RSVD_MID_MSB:`LDCC_RSVD_MID_LSB] == 5'h00);

  always @(posedge clock_i) begin
    if (srst_i) begin
      drv1_strength_select_o <= 1'b1;
      drv1_low_power_o <= 1'b0;
      drv1_edge_rate_o <= 3'h0;
      drv1_coarse_target_o <= 4'h0;
      drv1_fine_multiplier_o <= 5'h0C;
      drv1_rsvd_ok_o <= 1'b1;
      drv1_cfg_update_o <= 1'b0;
      drv2_strength_select_o <= 1'b1;
      drv2_low_power_o <= 1'b0;
      drv2_edge_rate_o <= 3'h0;
      drv2_coarse_target_o <= 4'h0;
      drv2_fine_multiplier_o <= 5'h0C;
      drv2_rsvd_ok_o <= 1'b1;
      drv2_cfg_update_o <= 1'b0;
    end else begin
      drv1_strength_select_o <= drv1_cfg_d[`LDCC_STRENGTH_BIT];
      drv1_low_power_o <= ~drv1_cfg_d[`LDCC_STRENGTH_BIT];
      drv1_edge_rate_o <= drv1_cfg_d[`LDCC_EDGE_MSB:`LDCC_EDGE_LSB];
      drv1_coarse_target_o <= drv1_cfg_d[`LDCC_COARSE_MSB:`LDCC_COARSE_LSB];
      drv1_fine_multiplier_o <= fine_adj_d[`LDCC_FINE1_MSB:`LDCC_FINE1_LSB];
      drv1_rsvd_ok_o <= drv1_rsvd_ok_d;
      drv1_cfg_update_o <= reg_wr_i & (hit_drv1 | hit_fine);
      drv2_strength_select_o <= drv2_cfg_d[`LDCC_STRENGTH_BIT];
      drv2_low_power_o <= ~drv2_cfg_d[`LDCC_STRENGTH_BIT];
      drv2_edge_rate_o <= drv2_cfg_d[`LDCC_EDGE_MSB:`LDCC_EDGE_LSB];
      drv2_coarse_target_o <= drv2_cfg_d[`LDCC_COARSE_MSB:`LDCC_COARSE_LSB];
      drv2_fine_multiplier_o <= fine_adj_d[`LDCC_FINE2_MSB:`LDCC_FINE2_LSB];
      drv2_rsvd_ok_o <= drv2_rsvd_ok_d;
      drv2_cfg_update_o <= reg_wr_i & (hit_drv2 | hit_fine);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Peak target current per driver

  wire [7:0] coarse_bus;
  wire [9:0] fine_bus;
  wire [1:0] strength_bus;
  wire [2*`LDCC_PEAK_W-1:0] peak_bus;

  assign coarse_bus = {drv2_cfg_q[`LDCC_COARSE_MSB:`LDCC_COARSE_LSB],
                       drv1_cfg_q[`LDCC_COARSE_MSB:`LDCC_COARSE_LSB]};
  assign fine_bus = {fine_adj_q[`LDCC_FINE2_MSB:`LDCC_FINE2_LSB],
                     fine_adj_q[`LDCC_FINE1_MSB:`LDCC_FINE1_LSB]};
  assign strength_bus = {drv2_cfg_q[`LDCC_STRENGTH_BIT], drv1_cfg_q[`LDCC_STRENGTH_BIT]};

  // Peak follows the stored registers, so it trails the field
  // outputs by three cycles; a host must not read it sooner
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1) begin : g_peak
      // Coarse x fine x scale, three cycles behind the register
      ldcc_peak u_peak (
        .clock_i(clock_i),
        .srst_i(srst_i),
        .coarse_i(coarse_bus[4*gi+3:4*gi]),
        .fine_i(fine_bus[5*gi+4:5*gi]),
        .strength_i(strength_bus[gi]),
        .peak_o(peak_bus[`LDCC_PEAK_W*gi+`LDCC_PEAK_W-1:`LDCC_PEAK_W*gi])
      );
    end
  endgenerate

  assign drv1_peak_o = peak_bus[`LDCC_PEAK_W-1:0];
  assign drv2_peak_o = peak_bus[2*`LDCC_PEAK_W-1:`LDCC_PEAK_W];

endmodule // ldcc_top

`default_nettype wire

// *** shared/ldcc_regs.vh ***
`ifndef LDCC_REGS_VH
`define LDCC_REGS_VH

// Register offsets on the register port
`define LDCC_ADDR_W 8
`define LDCC_OFS_DRV1_CFG 8'h23
`define LDCC_OFS_DRV2_CFG 8'h24
`define LDCC_OFS_FINE_ADJ 8'h25

// Reset values
`define LDCC_RST_DRV_CFG 16'h3000
`define LDCC_RST_FINE_ADJ 16'h630C

// Driver configuration fields
`define LDCC_STRENGTH_BIT 13
`define LDCC_RSVD_ONE_BIT 12
`define LDCC_RSVD_HI_MSB 15
`define LDCC_RSVD_HI_LSB 14
`define LDCC_RSVD_MID_MSB 11
`define LDCC_RSVD_MID_LSB 7
`define LDCC_EDGE_MSB 6
`define LDCC_EDGE_LSB 4
`define LDCC_COARSE_MSB 3
`define LDCC_COARSE_LSB 0

// Fine-adjust fields
`define LDCC_FINE1_MSB 4
`define LDCC_FINE1_LSB 0
`define LDCC_FINE2_MSB 10
`define LDCC_FINE2_LSB 6

// Peak current factors, fixed point
// Coarse in 0.1 mA: 503 + 198 * code
`define LDCC_COARSE_BASE 12'h1F7
`define LDCC_COARSE_STEP 12'h0C6
// Fine in 0.001: 740 + 22 * code
`define LDCC_FINE_BASE 11'h2E4
`define LDCC_FINE_STEP 11'h016
// Scale in 0.1: 4 or 10
`define LDCC_SCALE_LOW 4'h4
`define LDCC_SCALE_FULL 4'hA
// Peak result in units of 10 nA
`define LDCC_PEAK_W 26

`endif

// *** tb/ldcc_host.sv ***
`default_nettype none
module ldcc_host (
  input wire logic clock_i,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {addr_o, wdata_o, wr_o, rd_o} = '0;
  end
  // Released address and data show the inverse and both strobes drop, so stale values never look valid
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [15:0] d);
    @(negedge clock_i);
    {wr_o, rd_o, addr_o, wdata_o} = {w, r, a, d};
    @(negedge clock_i);
    {wr_o, rd_o, addr_o, wdata_o} = {2'h0, ~a, ~d};
  endtask
  task automatic wcfg(input logic [7:0] a, input logic s, input logic [2:0] e, input logic [3:0] c);
    acc(1'h1, 1'h0, a, {2'h0, s, 1'h1, 5'h00, e, c});
  endtask
endmodule // ldcc_host
`default_nettype wire

// *** tb/ldcc_props.sv ***
`include "ldcc_regs.vh"
`default_nettype none
module ldcc_props (
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic drv1_strength_select_o,
  input wire logic drv1_low_power_o,
  input wire logic [2:0] drv1_edge_rate_o,
  input wire logic [3:0] drv1_coarse_target_o,
  input wire logic [4:0] drv1_fine_multiplier_o,
  input wire logic [25:0] drv1_peak_o,
  input wire logic drv2_strength_select_o,
  input wire logic drv2_low_power_o,
  input wire logic [2:0] drv2_edge_rate_o,
  input wire logic [3:0] drv2_coarse_target_o,
  input wire logic [4:0] drv2_fine_multiplier_o,
  input wire logic [25:0] drv2_peak_o,
  input wire logic reg_wr_ack_o,
  input wire logic drv1_rsvd_ok_o,
  input wire logic drv1_cfg_update_o,
  input wire logic drv2_rsvd_ok_o,
  input wire logic drv2_cfg_update_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (srst_i);
  function automatic logic [25:0] pk(input logic [3:0] c, input logic [4:0] f, input logic s);
    return (26'h1F7 + 26'hC6 * c) * (26'h2E4 + 26'h16 * f) * (s ? 26'hA : 26'h4);
  endfunction
  sequence s_w1; reg_wr_i && reg_addr_i == `LDCC_OFS_DRV1_CFG; endsequence
  sequence s_w2; reg_wr_i && reg_addr_i == `LDCC_OFS_DRV2_CFG; endsequence
  sequence s_wf; reg_wr_i && reg_addr_i == `LDCC_OFS_FINE_ADJ; endsequence
  sequence s_calm; !$past(srst_i) && !$past(srst_i, 2) && !$past(srst_i, 3); endsequence
  a_drv1_scale: assert property (s_w1 |=>
    drv1_strength_select_o == $past(reg_wdata_i[13])
    && drv1_low_power_o == !$past(reg_wdata_i[13])) else $error("drv1 scale wrong");
  a_drv2_scale: assert property (s_w2 |=>
    drv2_strength_select_o == $past(reg_wdata_i[13])
    && drv2_low_power_o == !$past(reg_wdata_i[13])) else $error("drv2 scale wrong");
  a_drv1_edge: assert property (s_w1 |=> drv1_edge_rate_o == $past(reg_wdata_i[6:4]))
    else $error("drv1 edge rate wrong");
  a_drv2_edge: assert property (s_w2 |=> drv2_edge_rate_o == $past(reg_wdata_i[6:4]))
    else $error("drv2 edge rate wrong");
  a_drv1_coarse: assert property (s_w1 |=>
    drv1_coarse_target_o == $past(reg_wdata_i[3:0])) else $error("drv1 coarse wrong");
  a_drv2_coarse: assert property (s_w2 |=>
    drv2_coarse_target_o == $past(reg_wdata_i[3:0])) else $error("drv2 coarse wrong");
  a_fine_write: assert property (s_wf |=>
    drv1_fine_multiplier_o == $past(reg_wdata_i[4:0])
    && drv2_fine_multiplier_o == $past(reg_wdata_i[10:6])) else $error("fine fields wrong");
  a_drv1_peak: assert property (s_calm |-> drv1_peak_o ==
    pk($past(drv1_coarse_target_o, 3), $past(drv1_fine_multiplier_o, 3),
    $past(drv1_strength_select_o, 3))) else $error("drv1 peak");
  a_drv2_peak: assert property (s_calm |-> drv2_peak_o ==
    pk($past(drv2_coarse_target_o, 3), $past(drv2_fine_multiplier_o, 3),
    $past(drv2_strength_select_o, 3))) else $error("drv2 peak");
  a_drv1_rsvd: assert property (s_w1 |=> drv1_rsvd_ok_o ==
    ($past(reg_wdata_i[15:14]) == 2'h0 && $past(reg_wdata_i[12])
    && $past(reg_wdata_i[11:7]) == 5'h00)) else $error("drv1 reserved flag wrong");
  a_drv2_rsvd: assert property (s_w2 |=> drv2_rsvd_ok_o ==
    ($past(reg_wdata_i[15:14]) == 2'h0 && $past(reg_wdata_i[12])
    && $past(reg_wdata_i[11:7]) == 5'h00)) else $error("drv2 reserved flag wrong");
  a_write_ack: assert property (reg_wr_i |=> reg_wr_ack_o) else $error("write ack missing");
  a_drv1_update: assert property (reg_wr_i && (reg_addr_i == `LDCC_OFS_DRV1_CFG
    || reg_addr_i == `LDCC_OFS_FINE_ADJ) |=> drv1_cfg_update_o) else $error("drv1 update missing");
  a_drv2_update: assert property (reg_wr_i && (reg_addr_i == `LDCC_OFS_DRV2_CFG
    || reg_addr_i == `LDCC_OFS_FINE_ADJ) |=> drv2_cfg_update_o) else $error("drv2 update missing");
endmodule // ldcc_props
`default_nettype wire

// *** tb/testbench.sv ***
`include "ldcc_regs.vh"
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic clock_i = 1'h0;
  logic srst_i = 1'h1;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, rq[$], w;
  logic reg_wr_i, reg_rd_i, reg_rd_valid_o, reg_wr_ack_o, reg_addr_err_o, s, d;
  logic drv1_strength_select_o, drv1_low_power_o, drv1_rsvd_ok_o, drv1_cfg_update_o;
  logic drv2_strength_select_o, drv2_low_power_o, drv2_rsvd_ok_o, drv2_cfg_update_o;
  logic [2:0] drv1_edge_rate_o, drv2_edge_rate_o, e;
  logic [3:0] drv1_coarse_target_o, drv2_coarse_target_o, c;
  logic [4:0] drv1_fine_multiplier_o, drv2_fine_multiplier_o, f1, f2;
  logic [25:0] drv1_peak_o, drv2_peak_o;
  logic [31:0] r = 32'h6CBAC4B6;
  int fail_count = 0;
  int checked = 0;
  always #2 clock_i = ~clock_i;
  ldcc_top dut (.*);
  ldcc_host host (.clock_i(clock_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
    .wr_o(reg_wr_i), .rd_o(reg_rd_i));
  function automatic logic [25:0] pk(input logic [3:0] c, input logic [4:0] f, input logic s);
    return (26'h1F7 + 26'hC6 * c) * (26'h2E4 + 26'h16 * f) * (s ? 26'hA : 26'h4);
  endfunction
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    checked++;
    if (g !== x) begin
      fail_count++;
      $display("mismatch %s expected %0h seen %0h", n, x, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] x);
    rq.push_back(x);
    host.acc(1'h0, 1'h1, a, 16'h0000);
  endtask
  // Used at start and again mid-run: every field must come back to its reset value
  task automatic do_reset;
    srst_i = 1'h1;
    repeat (6) @(negedge clock_i);
    srst_i = 1'h0;
    repeat (4) @(negedge clock_i);
    chk("coarse", 8'h00, {drv1_coarse_target_o, drv2_coarse_target_o});
    chk("fine", 10'h18C, {drv1_fine_multiplier_o, drv2_fine_multiplier_o});
    chk("strength", 4'hA, {drv1_strength_select_o, drv1_low_power_o,
      drv2_strength_select_o, drv2_low_power_o});
    chk("edge", 6'h00, {drv1_edge_rate_o, drv2_edge_rate_o});
    chk("rsvd_ok", 2'h3, {drv1_rsvd_ok_o, drv2_rsvd_ok_o});
    chk("peak", 26'h4D0F08, drv1_peak_o);
    chk("peak", 26'h4D0F08, drv2_peak_o);
    rd(`LDCC_OFS_FINE_ADJ, `LDCC_RST_FINE_ADJ);
    rd(`LDCC_OFS_DRV1_CFG, `LDCC_RST_DRV_CFG);
  endtask
  task automatic report_and_stop;
    $display("checked %0d fail_count %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clock_i) begin
    if (reg_rd_valid_o === 1'h1) chk("rdata", rq.size() ? rq.pop_front() : 16'hDEAD, reg_rdata_o);
  end
  initial begin
    #40000;
    fail_count++;
    report_and_stop();
  end
  initial begin
    do_reset();
    for (int i = 0; i < 16; i++) begin
      r = lfsr(r);
      {d, s, e, c, f1, f2} = (i < 2) ? {i[0], 1'h0, 3'h7, 4'hF, 10'h3FF} : r[18:0];
      host.wcfg(d ? `LDCC_OFS_DRV2_CFG : `LDCC_OFS_DRV1_CFG, s, e, c);
      w = {5'h00, f2, 1'h0, f1};
      host.acc(1'h1, 1'h0, `LDCC_OFS_FINE_ADJ, w);
      repeat (4) @(negedge clock_i);
      chk("strength", {s, !s}, d ? {drv2_strength_select_o, drv2_low_power_o}
        : {drv1_strength_select_o, drv1_low_power_o});
      chk("edge", e, d ? drv2_edge_rate_o : drv1_edge_rate_o);
      chk("coarse", c, d ? drv2_coarse_target_o : drv1_coarse_target_o);
      chk("peak", pk(c, d ? f2 : f1, s), d ? drv2_peak_o : drv1_peak_o);
      rd(d ? `LDCC_OFS_DRV2_CFG : `LDCC_OFS_DRV1_CFG, {2'h0, s, 1'h1, 5'h00, e, c});
      rd(`LDCC_OFS_FINE_ADJ, w);
    end
    // Reserved pattern broken on purpose: flag drops, all bits still read back
    host.acc(1'h1, 1'h0, `LDCC_OFS_DRV1_CFG, 16'hC057);
    chk("wr_pulses", 3'h6, {reg_wr_ack_o, drv1_cfg_update_o, drv2_cfg_update_o});
    chk("rsvd_ok", 1'h0, drv1_rsvd_ok_o);
    chk("strength", 2'h1, {drv1_strength_select_o, drv1_low_power_o});
    chk("coarse", 4'h7, drv1_coarse_target_o);
    rd(`LDCC_OFS_DRV1_CFG, 16'hC057);
    do_reset();
    // Unmapped access must leave the fine and driver 2 registers untouched
    rq.push_back(16'h0000);
    host.acc(1'h1, 1'h1, 8'h26, 16'hFFFF);
    chk("addr_err", 1'h1, reg_addr_err_o);
    rd(`LDCC_OFS_FINE_ADJ, `LDCC_RST_FINE_ADJ);
    rd(`LDCC_OFS_DRV2_CFG, `LDCC_RST_DRV_CFG);
    repeat (3) @(negedge clock_i);
    report_and_stop();
  end
endmodule // testbench
bind ldcc_top ldcc_props props (.*);
`default_nettype wire
